// *** core/uib_irq_arbiter.sv ***
`timescale 1ns/1ps
module uib_irq_arbiter
  import uib_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt sources
  input  wire logic [11:0] rx_count_i,
  input  wire logic [3:0]  rx_parity_err_i,
  input  wire logic [3:0]  rx_frame_err_i,
  input  wire logic [3:0]  rx_overrun_i,
  input  wire logic [3:0]  rx_break_i,
  input  wire logic [11:0] tx_avail_i,
  input  wire logic [1:0]  ct_event_i,
  // General-purpose pins
  input  wire logic [15:0] io_pin_i,
  output logic      [15:0] io_pin_o,
  output logic      [15:0] io_pin_oe,
  // Interrupt request and acknowledge
  input  wire logic        irq_out_n_i,
  output logic             irq_out_n_o,
  output logic             irq_out_n_oe,
  input  wire logic        irq_ack_in_n,
  output logic      [7:0]  vector_o,
  output logic             vector_valid_o
);

  logic [31:0] ctrl_q;
  logic [17:0] mask_q;
  logic [15:0] pdir_q;
  logic [15:0] pout_q;
  logic [31:0] prio_q;
  logic [7:0]  cir_q;
  logic [31:0] dat_q;
  logic        ack_q;
  logic [31:0] rdata;
  logic [31:0] wmask;
  logic        wb_req;
  logic        wb_wr;
  logic        wb_rd;

  logic [15:0] pin_s1_q;
  logic [15:0] pin_s2_q;
  logic [15:0] pin_s3_q;
  logic [15:0] pin_val_q;
  logic        iack_s1_q;
  logic        iack_s2_q;
  logic        iack_s3_q;
  logic        iack_val_q;
  logic        iack_prev_q;
  logic        ack_fall;

  logic [7:0]  bid [NUM_SRC];
  logic [17:0] req_v;
  logic [3:0]  rx_err;
  logic [7:0]  win_bid;
  logic [7:0]  bid_latch_q;
  logic [7:0]  cir_next;
  logic [7:0]  thr;
  logic        div2;
  logic        eval;
  logic        eval_ph_q;
  logic        hold_q;
  logic        arb_take;
  logic        cir_upd;
  logic        irq_oe_q;
  logic        irq_o_q;
  logic [7:0]  vector_q;
  logic        vector_valid_q;

  uib_cos_if cos ();

  assign thr  = ctrl_q[CTRL_THR_LSB +: 8];
  assign div2 = ctrl_q[CTRL_DIV2_BIT];

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  assign wb_rd  = wb_req & ~wb_we_i;
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb begin
    case (wb_adr_i)
      ADDR_CTRL: rdata = ctrl_q;
      ADDR_MASK: rdata = {14'h0000, mask_q};
      ADDR_CIR:  rdata = {24'h00_0000, cir_q};
      ADDR_PDIR: rdata = {16'h0000, pdir_q};
      ADDR_POUT: rdata = {16'h0000, pout_q};
      ADDR_PIN:  rdata = {16'h0000, pin_val_q};
      ADDR_PCHG: rdata = {16'h0000, cos.level, cos.change};
      ADDR_PRIO: rdata = prio_q;
      ADDR_STAT: rdata = {15'h0000, irq_oe_q, ~bid_latch_q, bid_latch_q};
      default:   rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req;
      if (wb_req) begin
        dat_q <= wb_we_i ? 32'h0000_0000 : rdata;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  wb_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wb_req |=> ack_q ##1 !ack_q) else $error("bus ack not a single cycle");

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
    end else if (wb_wr && (wb_adr_i == ADDR_CTRL)) begin
      ctrl_q <= (ctrl_q & ~wmask) | (wb_dat_i & wmask);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mask_q <= MASK_RST;
    end else if (wb_wr && (wb_adr_i == ADDR_MASK)) begin
      mask_q <= (mask_q & ~wmask[17:0]) | (wb_dat_i[17:0] & wmask[17:0]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prio_q <= PRIO_RST;
    end else if (wb_wr && (wb_adr_i == ADDR_PRIO)) begin
      prio_q <= (prio_q & ~wmask) | (wb_dat_i & wmask);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pdir_q <= PIN_RST;
      pout_q <= PIN_RST;
    end else begin
      if (wb_wr && (wb_adr_i == ADDR_PDIR)) begin
        pdir_q <= (pdir_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
      if (wb_wr && (wb_adr_i == ADDR_POUT)) begin
        pout_q <= (pout_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
    end
  end

  // ----------------------------------------
  // Pin drivers and input synchronisers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      io_pin_o  <= PIN_RST;
      io_pin_oe <= PIN_RST;
    end else begin
      io_pin_o  <= pout_q;
      io_pin_oe <= pdir_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_s1_q  <= PIN_RST;
      pin_s2_q  <= PIN_RST;
      pin_s3_q  <= PIN_RST;
      pin_val_q <= PIN_RST;
    end else begin
      pin_s1_q  <= io_pin_i;
      pin_s2_q  <= pin_s1_q;
      pin_s3_q  <= pin_s2_q;
      pin_val_q <= (pin_s2_q & pin_s3_q) | (pin_val_q & (pin_s2_q | pin_s3_q));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      iack_s1_q   <= 1'b1;
      iack_s2_q   <= 1'b1;
      iack_s3_q   <= 1'b1;
      iack_val_q  <= 1'b1;
      iack_prev_q <= 1'b1;
    end else begin
      iack_s1_q   <= irq_ack_in_n;
      iack_s2_q   <= iack_s1_q;
      iack_s3_q   <= iack_s2_q;
      iack_val_q  <= (iack_s2_q == iack_s3_q) ? iack_s3_q : iack_val_q;
      iack_prev_q <= iack_val_q;
    end
  end

  assign ack_fall = iack_prev_q & ~iack_val_q;

  // ----------------------------------------
  // Change detectors
  // ----------------------------------------
  assign cos.clear = wb_rd && (wb_adr_i == ADDR_PCHG);

  uib_cos_detect u_cos (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .cos     (cos.det)
  );

  // ----------------------------------------
  // Bid formation
  // ----------------------------------------
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    assign cos.level[2*ch +: 2] = pin_val_q[4*ch +: 2];
    assign rx_err[ch] = rx_parity_err_i[ch] | rx_frame_err_i[ch] | rx_overrun_i[ch];
    assign bid[SRC_RX+ch]   = {rx_count_i[3*ch +: 3], rx_err[ch], TYPE_RX, 2'(ch)};
    assign bid[SRC_TX+ch]   = {1'b0, tx_avail_i[3*ch +: 3], TYPE_TX, 2'(ch)};
    assign bid[SRC_BRK+ch]  = {prio_q[PRIO_BRK_LSB+3*ch +: 3], TYPE_BRK, 2'(ch)};
    assign bid[SRC_COS+ch]  = {prio_q[PRIO_COS_LSB+3*ch +: 3], TYPE_COS, 2'(ch)};
    assign req_v[SRC_RX+ch]  = |rx_count_i[3*ch +: 3];
    assign req_v[SRC_TX+ch]  = |tx_avail_i[3*ch +: 3];
    assign req_v[SRC_BRK+ch] = rx_break_i[ch];
    assign req_v[SRC_COS+ch] = |cos.change[2*ch +: 2];
  end

  for (genvar k = 0; k < NUM_CT; k++) begin : g_ct
    assign bid[SRC_CT+k]   = {prio_q[PRIO_CT_LSB+2*k +: 2], TYPE_CT, (k == 0) ? CT_CH0 : CT_CH1};
    assign req_v[SRC_CT+k] = ct_event_i[k];
  end

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  always_comb begin
    win_bid = NO_BID;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (req_v[i] && mask_q[i] && (bid[i] > win_bid)) begin
        win_bid = bid[i];
      end
    end
  end

  assign eval     = ~div2 | eval_ph_q;
  assign arb_take = eval & ~hold_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      eval_ph_q <= 1'b0;
    end else begin
      eval_ph_q <= ~eval_ph_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hold_q <= 1'b0;
    end else if (ack_fall) begin
      hold_q <= ~eval;
    end else if (eval) begin
      hold_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bid_latch_q <= NO_BID;
    end else if (arb_take) begin
      bid_latch_q <= win_bid;
    end
  end

  eval_full_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !div2 |-> eval) else $error("arbitration skipped without divider");
  eval_half_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (div2 && eval) ##1 div2 |-> !eval) else $error("arbitration ran twice in a row with divider");
  mask_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (arb_take && (mask_q == 18'h0_0000)) |=> (bid_latch_q == NO_BID)) else $error("masked source won");
  win_latch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    arb_take |=> (bid_latch_q == $past(win_bid))) else $error("winner not latched");
  ack_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ack_fall && !eval) |=> !arb_take) else $error("arbitration not held after acknowledge");

  // ----------------------------------------
  // Request output
  // ----------------------------------------
  // Level follows every arbitration, so a lone FIFO source
  // can drop out briefly while its count is being changed.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_oe_q <= 1'b0;
      irq_o_q  <= 1'b0;
    end else begin
      irq_oe_q <= (bid_latch_q > thr);
      irq_o_q  <= 1'b0;
    end
  end

  assign irq_out_n_oe = irq_oe_q;
  assign irq_out_n_o  = irq_o_q;

  irq_assert_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bid_latch_q > thr) |=> irq_oe_q) else $error("request missing above threshold");
  irq_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bid_latch_q <= thr) |=> !irq_oe_q) else $error("request held at or below threshold");

  // ----------------------------------------
  // Current winner and vector
  // ----------------------------------------
  assign cir_upd  = ack_fall | (wb_wr && (wb_adr_i == ADDR_CIR));
  assign cir_next = (bid_latch_q > thr) ? bid_latch_q : CIR_NONE;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cir_q <= CIR_NONE;
    end else if (cir_upd) begin
      cir_q <= cir_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vector_q       <= 8'h00;
      vector_valid_q <= 1'b0;
    end else begin
      vector_valid_q <= ack_fall;
      if (ack_fall) begin
        vector_q <= ctrl_q[CTRL_VMOD_BIT] ?
                    {ctrl_q[CTRL_VBASE_LSB+5 +: 3], cir_next[4:0]} :
                    ctrl_q[CTRL_VBASE_LSB +: 8];
      end
    end
  end

  assign vector_o       = vector_q;
  assign vector_valid_o = vector_valid_q;

  cir_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ack_fall |=> (cir_q == $past(cir_next)) && vector_valid_q) else $error("winner not captured on acknowledge");

endmodule

// *** shared/uib_pkg.sv ***
// Operation
// - Sixteen pins, each input or output
// - Two pins per channel sampled for changes
// - Change detection ignores pin direction
// - Reading change register resets the reference
// - Eighteen interrupt sources in five kinds
// - Each source forms a numeric bid
// - Arbitrate every cycle or every second
// - Masked sources place no bid
// - Bid concatenates channel, type, level, programmable
// - All enabled bids compete together
// - Largest bid alone remains as winner
// - Use divide-by-2 above 4 MHz
// - Request only when winner exceeds threshold
// - Request is open-drain active-low level
// - Request may pulse during FIFO access
// - Acknowledge latches winner and returns vector
// - Channel number in two lowest bits
// - No bids reads FFh, request negated
// - Receive error is OR of errors
// - Timers report channel codes 01, 11
package uib_pkg;

  localparam int CLK_PERIOD_NS  = 50;
  localparam int COS_SAMPLE_NS  = 26040;
  localparam int COS_SAMPLE_CYC = COS_SAMPLE_NS / CLK_PERIOD_NS;

  localparam int NUM_CH   = 4;
  localparam int NUM_PINS = 16;
  localparam int NUM_COS  = 8;
  localparam int NUM_CT   = 2;
  localparam int NUM_SRC  = 18;

  localparam int SRC_RX  = 0;
  localparam int SRC_BRK = 4;
  localparam int SRC_TX  = 8;
  localparam int SRC_COS = 12;
  localparam int SRC_CT  = 16;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_CIR  = 8'h08;
  localparam logic [7:0] ADDR_PDIR = 8'h0C;
  localparam logic [7:0] ADDR_POUT = 8'h10;
  localparam logic [7:0] ADDR_PIN  = 8'h14;
  localparam logic [7:0] ADDR_PCHG = 8'h18;
  localparam logic [7:0] ADDR_PRIO = 8'h1C;
  localparam logic [7:0] ADDR_STAT = 8'h20;

  localparam int CTRL_THR_LSB   = 0;
  localparam int CTRL_DIV2_BIT  = 8;
  localparam int CTRL_VMOD_BIT  = 9;
  localparam int CTRL_VBASE_LSB = 16;
  localparam int PRIO_BRK_LSB   = 0;
  localparam int PRIO_COS_LSB   = 12;
  localparam int PRIO_CT_LSB    = 24;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [17:0] MASK_RST = 18'h0_0000;
  localparam logic [15:0] PIN_RST  = 16'h0000;
  localparam logic [31:0] PRIO_RST = 32'h0000_0000;

  localparam logic [1:0] TYPE_RX  = 2'h3;
  localparam logic [1:0] TYPE_TX  = 2'h2;
  localparam logic [2:0] TYPE_BRK = 3'h4;
  localparam logic [2:0] TYPE_COS = 3'h1;
  localparam logic [3:0] TYPE_CT  = 4'h5;
  localparam logic [1:0] CT_CH0   = 2'h1;
  localparam logic [1:0] CT_CH1   = 2'h3;
  localparam logic [7:0] NO_BID   = 8'h00;
  localparam logic [7:0] CIR_NONE = 8'hFF;

endpackage

// *** shared/uib_cos_if.sv ***
`timescale 1ns/1ps
interface uib_cos_if;
  logic [7:0] level;
  logic [7:0] change;
  logic       clear;
  modport det (input level, input clear, output change);
  modport ctl (output level, output clear, input change);
endinterface

// *** core/uib_cos_detect.sv ***
`timescale 1ns/1ps
module uib_cos_detect
  import uib_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Detector link
  uib_cos_if.det    cos
);

  logic [9:0] smp_cnt_q;
  logic       sample;
  logic [7:0] ref_q;
  logic [7:0] chg_q;

  assign sample     = (smp_cnt_q == 10'(COS_SAMPLE_CYC - 1));
  assign cos.change = chg_q;

  // ----------------------------------------
  // Sample period
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      smp_cnt_q <= 10'h000;
    end else if (sample) begin
      smp_cnt_q <= 10'h000;
    end else begin
      smp_cnt_q <= smp_cnt_q + 10'h001;
    end
  end

  // ----------------------------------------
  // Per-pin detectors
  // ----------------------------------------
  for (genvar i = 0; i < NUM_COS; i++) begin : g_det
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        ref_q[i] <= 1'b0;
        chg_q[i] <= 1'b0;
      end else begin
        if (cos.clear) begin
          ref_q[i] <= cos.level[i];
        end
        if (sample && (cos.level[i] != ref_q[i])) begin
          chg_q[i] <= 1'b1;
        end else if (cos.clear) begin
          chg_q[i] <= 1'b0;
        end
      end
    end
  end

  cos_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cos.clear && !sample) |=> (chg_q == 8'h00)) else $error("change flags not cleared by read");

endmodule

// *** sim/uib_host_model.sv ***
`timescale 1ns/1ps
module uib_host_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Bench side
  input  wire logic       go,
  output logic      [7:0] vec,
  output logic            done,
  // Device side
  input  wire logic [7:0] vector_i,
  input  wire logic       vector_valid_i,
  output logic            irq_ack_in_n
);
  int n;
  // Acknowledge: hold low until the vector arrives, then idle high
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_ack_in_n <= 1'b1;
      vec <= 8'h00;
      done <= 1'b0;
    end else if (go) begin
      done <= 1'b0;
      irq_ack_in_n <= 1'b0;
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (vector_valid_i !== 1'b1 && n < 40);
      vec <= vector_i;
      irq_ack_in_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      done <= 1'b1;
    end
  end
endmodule

// *** sim/tb_uib_irq_arbiter.sv ***
`timescale 1ns/1ps
module tb_uib_irq_arbiter;
  import uib_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [11:0] rx_count_i = 12'h000;
  logic [3:0]  rx_parity_err_i = 4'h0;
  logic [3:0]  rx_frame_err_i = 4'h0;
  logic [3:0]  rx_overrun_i = 4'h0;
  logic [3:0]  rx_break_i = 4'h0;
  logic [11:0] tx_avail_i = 12'h000;
  logic [1:0]  ct_event_i = 2'h0;
  logic [15:0] io_pin_i = 16'h0000;
  logic [15:0] io_pin_o;
  logic [15:0] io_pin_oe;
  logic        irq_out_n_o;
  logic        irq_out_n_oe;
  logic        irq_wire_n;
  logic        irq_ack_in_n;
  logic [7:0]  vector_o;
  logic        vector_valid_o;
  logic        go = 1'b0;
  logic [7:0]  vec;
  logic        done;
  int          n_mismatch = 0;
  int          checked = 0;

  always #25 ref_clk = ~ref_clk;
  // Open-drain request wire with pull-up
  assign irq_wire_n = irq_out_n_oe ? irq_out_n_o : 1'b1;

  uib_irq_arbiter uib_irq_arbiter_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_count_i(rx_count_i),
    .rx_parity_err_i(rx_parity_err_i), .rx_frame_err_i(rx_frame_err_i),
    .rx_overrun_i(rx_overrun_i), .rx_break_i(rx_break_i), .tx_avail_i(tx_avail_i),
    .ct_event_i(ct_event_i), .io_pin_i(io_pin_i), .io_pin_o(io_pin_o), .io_pin_oe(io_pin_oe),
    .irq_out_n_i(irq_wire_n), .irq_out_n_o(irq_out_n_o), .irq_out_n_oe(irq_out_n_oe),
    .irq_ack_in_n(irq_ack_in_n), .vector_o(vector_o), .vector_valid_o(vector_valid_o));

  uib_host_model uib_host_model_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .go(go), .vec(vec), .done(done),
    .vector_i(vector_o), .vector_valid_i(vector_valid_o), .irq_ack_in_n(irq_ack_in_n));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      final_report();
    end
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask

  // Arbitration result with its request state
  function automatic logic [31:0] stat(input logic [7:0] b, input logic act);
    return {15'h0, act, ~b, b};
  endfunction

  function automatic logic [31:0] ctrl(input logic [7:0] t, input logic d2, input logic vm, input logic [7:0] b);
    return {8'h00, b, 6'h00, vm, d2, t};
  endfunction

  task automatic settle();
    repeat (6) @(posedge ref_clk);
  endtask

  task automatic ack_cycle(input logic [7:0] ev, input logic [7:0] ecir);
    int n;
    n = 0;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    while (done !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 60) begin
      n_mismatch++;
      final_report();
    end
    chk("vector", {24'h0, ev}, {24'h0, vec});
    rd("cir", ADDR_CIR, {24'h0, ecir});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd("cir_rst", ADDR_CIR, 32'hFF);
    rd("stat_rst", ADDR_STAT, stat(NO_BID, 1'b0));
    wr(8'h24, 32'hFFFF_FFFF);
    rd("unmapped", 8'h24, 32'h0);
    chk("irq_idle", 32'h1, {31'h0, irq_wire_n});
    $display("test reset done");

    wr(ADDR_CTRL, ctrl(8'h00, 1'b1, 1'b0, 8'hA0));
    wr(ADDR_MASK, 32'h4);
    rx_count_i[8:6] <= 3'h5;
    for (int i = 0; i < 4; i++) begin
      rx_parity_err_i <= (i == 1) ? 4'h4 : 4'h0;
      rx_frame_err_i <= (i == 2) ? 4'h4 : 4'h0;
      rx_overrun_i <= (i == 3) ? 4'h4 : 4'h0;
      settle();
      rd("rx_bid", ADDR_STAT, stat((i == 0) ? 8'hAE : 8'hBE, 1'b1));
    end
    chk("irq_low", 32'h0, {31'h0, irq_wire_n});
    wr(ADDR_CTRL, ctrl(8'hBE, 1'b1, 1'b0, 8'hA0));
    settle();
    chk("thr_eq", 32'h1, {31'h0, irq_wire_n});
    wr(ADDR_CTRL, ctrl(8'hBD, 1'b1, 1'b0, 8'hA0));
    settle();
    chk("thr_below", 32'h0, {31'h0, irq_wire_n});
    wr(ADDR_MASK, 32'h0);
    settle();
    rd("masked", ADDR_STAT, stat(NO_BID, 1'b0));
    $display("test rx bid done");

    rx_overrun_i <= 4'h0;
    wr(ADDR_CTRL, ctrl(8'h00, 1'b0, 1'b0, 8'hA0));
    wr(ADDR_MASK, 32'h3_FFFF);
    rx_count_i[8:6] <= 3'h0;
    settle();
    rd("rx_empty", ADDR_STAT, stat(NO_BID, 1'b0));
    tx_avail_i[5:3] <= 3'h7;
    repeat (2) @(posedge ref_clk);
    chk("div1_e1", 32'h1, {31'h0, irq_wire_n});
    @(posedge ref_clk);
    chk("div1_e2", 32'h0, {31'h0, irq_wire_n});
    rd("tx_bid", ADDR_STAT, stat(8'h79, 1'b1));
    rx_count_i[8:6] <= 3'h5;
    rx_break_i[3] <= 1'b1;
    wr(ADDR_PRIO, 32'hE00);
    settle();
    rd("brk_win", ADDR_STAT, stat(8'hF3, 1'b1));
    wr(ADDR_PRIO, 32'h0);
    settle();
    rd("rx_win", ADDR_STAT, stat(8'hAE, 1'b1));
    for (int k = 0; k < 2; k++) begin
      ct_event_i <= (k == 0) ? 2'h1 : 2'h2;
      wr(ADDR_PRIO, (k == 0) ? 32'h0300_0000 : 32'h0C00_0000);
      settle();
      rd("ct_bid", ADDR_STAT, stat((k == 0) ? 8'hD5 : 8'hD7, 1'b1));
    end
    $display("test arbitration done");

    ack_cycle(8'hA0, 8'hD7);
    wr(ADDR_CTRL, ctrl(8'h00, 1'b1, 1'b1, 8'hA0));
    settle();
    ack_cycle(8'hB7, 8'hD7);
    wr(ADDR_CTRL, ctrl(8'hE0, 1'b1, 1'b1, 8'hA0));
    settle();
    ack_cycle(8'hBF, 8'hFF);
    wr(ADDR_CTRL, ctrl(8'h00, 1'b1, 1'b1, 8'hA0));
    settle();
    wr(ADDR_CIR, 32'h0);
    rd("cir_upd", ADDR_CIR, 32'hD7);
    $display("test acknowledge done");

    wr(ADDR_PDIR, 32'hFFFF);
    wr(ADDR_POUT, 32'h1234);
    @(posedge ref_clk);
    chk("pin_oe", 32'hFFFF, {16'h0, io_pin_oe});
    chk("pin_out", 32'h1234, {16'h0, io_pin_o});
    rd("pchg_idle", ADDR_PCHG, 32'h0);
    io_pin_i[0] <= 1'b1;
    repeat (1100) @(posedge ref_clk);
    rd("pchg_set", ADDR_PCHG, 32'h0101);
    rd("pchg_clr", ADDR_PCHG, 32'h0100);
    $display("test pins done");
    final_report();
  end
endmodule
